// File: common/smcp_pkg.sv
// Constants shared by the serial memory command port.
package smcp_pkg;
    localparam logic [7:0] LATCH_SET_CMD     = 8'h06;
    localparam logic [7:0] LATCH_CLEAR_CMD   = 8'h04;
    localparam logic [7:0] STATUS_READ_CMD   = 8'h05;
    localparam logic [7:0] STATUS_WRITE_CMD  = 8'h01;
    localparam logic [7:0] MEM_READ_CMD      = 8'h03;
    localparam logic [7:0] MEM_WRITE_CMD     = 8'h02;
    localparam logic [7:0] COMPANION_READ_CMD  = 8'h13;
    localparam logic [7:0] COMPANION_WRITE_CMD = 8'h12;
    localparam int         MEM_AW            = 15;
    localparam int         MEM_DEPTH         = 32768;
    localparam logic [7:0] COMP_LAST_ADDR    = 8'h1d;
    localparam int         COMP_DEPTH        = 30;
    localparam int         STAT_BP_HI_POS    = 3;
    localparam int         STAT_BP_LO_POS    = 2;
    localparam int         STAT_LATCH_POS    = 1;
    localparam logic [7:0] STAT_FIXED        = 8'h40;
    localparam logic [1:0] BP_RESET          = 2'h0;
    localparam logic [14:0] QUARTER_BASE     = 15'h6000;
    localparam logic [14:0] HALF_BASE        = 15'h4000;
    localparam int         FIFO_DEPTH        = 8;
    localparam int         BYTE_W            = 8;

    typedef enum logic [2:0] {
        SMCP_OPCODE = 3'b000,
        SMCP_ADDR_HI = 3'b001,
        SMCP_ADDR_LO = 3'b010,
        SMCP_DATA   = 3'b011,
        SMCP_IGNORE = 3'b100
    } smcp_phase_t;
endpackage : smcp_pkg

// File: rtl/smcp_top.sv
// Serial memory command port with write buffer, memory array and registers.
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Write buffer
// ****************************************
module smcp_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input  wire logic         clk_i,   // Clock
    input  wire logic         rst_i,   // Sync reset
    input  wire logic         s_valid_i, // Fill side valid
    output logic              s_ready_o, // Fill side ready
    input  wire logic [W-1:0] s_data_i,  // Fill side data
    output logic              m_valid_o, // Drain side valid
    input  wire logic         m_ready_i, // Drain side ready
    output logic [W-1:0]      m_data_o   // Drain side data
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem_q [D];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0]   cnt_q;
    logic          push;
    logic          pop;

    assign s_ready_o = (cnt_q != (AW+1)'(D));
    assign m_valid_o = (cnt_q != '0);
    assign m_data_o  = mem_q[rp_q];
    assign push      = s_valid_i && s_ready_o;
    assign pop       = m_valid_o && m_ready_i;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wp_q] <= s_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // smcp_fifo

// ****************************************
// Command port
// ****************************************
module smcp_top
    import smcp_pkg::*;
(
    input  wire logic       CLK_I,      // 10 MHz system clock
    input  wire logic       RST_I,      // Sync reset, active high
    input  wire logic       SCK_I,      // Serial clock pin
    input  wire logic       CS_N_I,     // Chip select pin, active low
    input  wire logic       SI_I,       // Serial data in pin
    output logic            SO_O,       // Serial data out
    output logic            SO_OE_O,    // Serial out enable
    output logic            MODE3_O,    // Mode seen at last select fall
    output logic [7:0]      STATUS_O    // Status register image
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [1:0] sck_s_q, cs_s_q, si_s_q;
    logic       sck_d1_q, cs_d1_q;
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            sck_s_q  <= 2'h0;
            cs_s_q   <= 2'h3;
            si_s_q   <= 2'h0;
            sck_d1_q <= 1'b0;
            cs_d1_q  <= 1'b1;
        end else begin
            sck_s_q  <= {sck_s_q[0], SCK_I};
            cs_s_q   <= {cs_s_q[0], CS_N_I};
            si_s_q   <= {si_s_q[0], SI_I};
            sck_d1_q <= sck_s_q[1];
            cs_d1_q  <= cs_s_q[1];
        end
    end
    logic sck, cs_n, si, sck_rise, sck_fall, cs_fall, cs_rise;
    assign sck      = sck_s_q[1];
    assign cs_n     = cs_s_q[1];
    assign si       = si_s_q[1];
    assign sck_rise = sck && !sck_d1_q && !cs_n;
    assign sck_fall = !sck && sck_d1_q && !cs_n;
    assign cs_fall  = !cs_n && cs_d1_q;
    assign cs_rise  = cs_n && !cs_d1_q;

    // ****************************************
    // Frame state
    // ****************************************
    smcp_phase_t phase_q;
    logic [2:0]  bit_q;
    logic [7:0]  shin_q;
    logic [7:0]  op_q;
    logic [7:0]  shout_q;
    logic [14:0] maddr_q;
    logic [7:0]  caddr_q;
    logic        latch_q;
    logic [1:0]  bp_q;
    logic        stop_q;
    logic [7:0]  mem_q [MEM_DEPTH];
    logic [7:0]  comp_q [COMP_DEPTH];
    logic [7:0]  status;
    logic [7:0]  rx_byte;
    logic        byte_done;
    logic        protect;
    logic [14:0] waddr;

    assign rx_byte   = {shin_q[6:0], si};
    assign byte_done = sck_rise && (bit_q == 3'h7);
    assign status    = STAT_FIXED | ({6'h0, latch_q, 1'b0})
                     | ({4'h0, bp_q, 2'h0});

    function automatic logic prot(input logic [1:0] bp, input logic [14:0] a);
        case (bp)
            2'h0:    prot = 1'b0;
            2'h1:    prot = (a >= QUARTER_BASE);
            2'h2:    prot = (a >= HALF_BASE);
            default: prot = 1'b1;
        endcase
    endfunction

    // Mode capture at select fall
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            MODE3_O <= 1'b0;
        end else if (cs_fall) begin
            MODE3_O <= sck;
        end
    end

    // Bit counter and input shifter, sampling on rising edges
    always_ff @(posedge CLK_I) begin
        if (RST_I || cs_fall) begin
            bit_q  <= 3'h0;
            shin_q <= 8'h0;
        end else if (sck_rise) begin
            bit_q  <= bit_q + 3'h1;
            shin_q <= rx_byte;
        end
    end

    // Write buffer: bytes wait here before being committed
    logic       wb_valid, wb_ready, wb_out_valid;
    logic [7:0] wb_data;
    logic       wr_req;
    logic [14:0] wb_addr_q [FIFO_DEPTH];
    assign wr_req = byte_done && phase_q == SMCP_DATA && op_q == MEM_WRITE_CMD
                  && latch_q && !stop_q && !protect;
    assign wb_valid = wr_req;
    smcp_fifo #(.W(BYTE_W), .D(FIFO_DEPTH)) u_wbuf (
        .clk_i     (CLK_I),
        .rst_i     (RST_I),
        .s_valid_i (wb_valid),
        .s_ready_o (wb_ready),
        .s_data_i  (rx_byte),
        .m_valid_o (wb_out_valid),
        .m_ready_i (1'b1),
        .m_data_o  (wb_data)
    );
    // Address travels beside the data; drain commits one byte per clock
    logic [2:0] awp_q, arp_q;
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            awp_q <= 3'h0;
            arp_q <= 3'h0;
        end else begin
            if (wb_valid && wb_ready) begin
                awp_q <= awp_q + 3'h1;
            end
            if (wb_out_valid) begin
                arp_q <= arp_q + 3'h1;
            end
        end
    end
    always_ff @(posedge CLK_I) begin
        if (wb_valid && wb_ready) begin
            wb_addr_q[awp_q] <= maddr_q;
        end
    end
    assign waddr   = wb_addr_q[arp_q];
    assign protect = prot(bp_q, maddr_q);
    always_ff @(posedge CLK_I) begin
        if (wb_out_valid) begin
            mem_q[waddr] <= wb_data;
        end
    end

    // Command sequencer
    always_ff @(posedge CLK_I) begin
        if (RST_I || cs_fall) begin
            phase_q <= SMCP_OPCODE;
            op_q    <= 8'h0;
            maddr_q <= 15'h0;
            caddr_q <= 8'h0;
            stop_q  <= 1'b0;
        end else if (byte_done) begin
            case (phase_q)
                SMCP_OPCODE: begin
                    op_q <= rx_byte;
                    if (rx_byte == MEM_READ_CMD || rx_byte == MEM_WRITE_CMD) begin
                        phase_q <= SMCP_ADDR_HI;
                    end else if (rx_byte == COMPANION_READ_CMD
                                 || rx_byte == COMPANION_WRITE_CMD) begin
                        phase_q <= SMCP_ADDR_LO;
                    end else if (rx_byte == STATUS_READ_CMD
                                 || rx_byte == STATUS_WRITE_CMD) begin
                        phase_q <= SMCP_DATA;
                    end else begin
                        phase_q <= SMCP_IGNORE;
                    end
                end
                SMCP_ADDR_HI: begin
                    maddr_q[14:8] <= rx_byte[6:0];
                    phase_q       <= SMCP_ADDR_LO;
                end
                SMCP_ADDR_LO: begin
                    if (op_q[4]) begin
                        caddr_q <= rx_byte;
                    end else begin
                        maddr_q[7:0] <= rx_byte;
                    end
                    phase_q <= SMCP_DATA;
                end
                SMCP_DATA: begin
                    if (op_q[4]) begin
                        caddr_q <= (caddr_q >= COMP_LAST_ADDR) ? 8'h0
                                 : caddr_q + 8'h1;
                    end else if (op_q == MEM_READ_CMD || op_q == MEM_WRITE_CMD) begin
                        maddr_q <= maddr_q + 15'h1;
                    end else begin
                        phase_q <= SMCP_IGNORE;
                    end
                    if (op_q == MEM_WRITE_CMD && (protect || !wb_ready)) begin
                        stop_q <= 1'b1;
                    end
                end
                default: phase_q <= SMCP_IGNORE;
            endcase
        end
    end

    // Companion and status writes
    always_ff @(posedge CLK_I) begin
        if (byte_done && phase_q == SMCP_DATA && op_q == COMPANION_WRITE_CMD
            && latch_q && caddr_q <= COMP_LAST_ADDR) begin
            comp_q[caddr_q[4:0]] <= rx_byte;
        end
    end
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            bp_q <= BP_RESET;
        end else if (byte_done && phase_q == SMCP_DATA
                     && op_q == STATUS_WRITE_CMD && latch_q) begin
            bp_q <= {rx_byte[STAT_BP_HI_POS], rx_byte[STAT_BP_LO_POS]};
        end
    end

    // Write-enable latch
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            latch_q <= 1'b0;
        end else if (cs_rise && phase_q != SMCP_OPCODE) begin
            if (op_q == LATCH_SET_CMD) begin
                latch_q <= 1'b1;
            end else if (op_q == LATCH_CLEAR_CMD || op_q == STATUS_WRITE_CMD
                         || op_q == COMPANION_WRITE_CMD
                         || op_q == MEM_WRITE_CMD) begin
                latch_q <= 1'b0;
            end
        end
    end

    // Output shifter: loads at a byte boundary, shifts on falling edges
    logic       rd_phase;
    logic [7:0] load_byte;
    assign rd_phase = (op_q == STATUS_READ_CMD && phase_q == SMCP_DATA)
                    || op_q == MEM_READ_CMD || op_q == COMPANION_READ_CMD;
    always_comb begin
        load_byte = 8'h0;
        if (phase_q == SMCP_OPCODE && rx_byte == STATUS_READ_CMD) begin
            load_byte = status;
        end else if (op_q == MEM_READ_CMD) begin
            load_byte = (phase_q == SMCP_ADDR_LO)
                      ? mem_q[{maddr_q[14:8], rx_byte}]
                      : mem_q[maddr_q + 15'h1];
        end else if (op_q == COMPANION_READ_CMD) begin
            if (phase_q == SMCP_ADDR_LO) begin
                load_byte = (rx_byte <= COMP_LAST_ADDR) ? comp_q[rx_byte[4:0]] : 8'h0;
            end else begin
                load_byte = (caddr_q >= COMP_LAST_ADDR) ? comp_q[0]
                          : comp_q[caddr_q[4:0] + 5'h1];
            end
        end
    end
    logic load_q;
    always_ff @(posedge CLK_I) begin
        if (RST_I || cs_fall) begin
            load_q  <= 1'b0;
            shout_q <= 8'h0;
        end else if (byte_done) begin
            load_q <= (phase_q == SMCP_OPCODE && rx_byte == STATUS_READ_CMD)
                   || ((op_q == MEM_READ_CMD || op_q == COMPANION_READ_CMD)
                       && (phase_q == SMCP_ADDR_LO || phase_q == SMCP_DATA));
            shout_q <= load_byte;
        end else if (sck_fall && load_q) begin
            shout_q <= {shout_q[6:0], 1'b0};
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            SO_O     <= 1'b0;
            SO_OE_O  <= 1'b0;
            STATUS_O <= STAT_FIXED;
        end else begin
            STATUS_O <= status;
            if (cs_n) begin
                SO_OE_O <= 1'b0;
            end else if (sck_fall && load_q && rd_phase) begin
                SO_OE_O <= 1'b1;
                SO_O    <= shout_q[7];
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    property p_latch_rst;
        @(posedge CLK_I) RST_I |=> !latch_q;
    endproperty
    a_latch_rst: assert property (p_latch_rst) else $error("latch not clear after reset");

    property p_latch_clr;
        @(posedge CLK_I) disable iff (RST_I)
        (cs_rise && phase_q != SMCP_OPCODE && op_q == MEM_WRITE_CMD) |=> !latch_q;
    endproperty
    a_latch_clr: assert property (p_latch_clr) else $error("latch kept after write");

    property p_fixed;
        @(posedge CLK_I) disable iff (RST_I) (STATUS_O & 8'hb1) == 8'h0 && STATUS_O[6];
    endproperty
    a_fixed: assert property (p_fixed) else $error("fixed status bits wrong");

    property p_nolatch;
        @(posedge CLK_I) disable iff (RST_I) !latch_q |-> !wr_req;
    endproperty
    a_nolatch: assert property (p_nolatch) else $error("write while latch clear");

    property p_bp_hold;
        @(posedge CLK_I) disable iff (RST_I) !latch_q |=> $stable(bp_q);
    endproperty
    a_bp_hold: assert property (p_bp_hold) else $error("protect bits moved");

    property p_prot;
        @(posedge CLK_I) disable iff (RST_I) (bp_q == 2'h3) |-> !wr_req;
    endproperty
    a_prot: assert property (p_prot) else $error("write into protected array");

    property p_mode;
        @(posedge CLK_I) disable iff (RST_I) cs_fall |=> MODE3_O == $past(sck);
    endproperty
    a_mode: assert property (p_mode) else $error("mode not captured");

    sequence s_opcode_done;
        byte_done && phase_q == SMCP_OPCODE;
    endsequence
    property p_op;
        @(posedge CLK_I) disable iff (RST_I) s_opcode_done |=> phase_q != SMCP_OPCODE;
    endproperty
    a_op: assert property (p_op) else $error("op-code not taken");
endmodule // smcp_top
`default_nettype wire

// File: testbench/smcp_host_model.sv
// Host-side serial master model for the command port.
`timescale 1ns/1ps
`default_nettype none

// ********
// Serial master
// ********
module smcp_host_model (
    input  wire logic clk_i,   // System clock for pacing
    input  wire logic so_i,    // Data from the port
    input  wire logic so_oe_i, // Port output enable
    output logic      sck_o,   // Serial clock
    output logic      cs_n_o,  // Select, active low
    output logic      si_o     // Data to the port
);
    logic mode3_q;

    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
        mode3_q = 1'b0;
    end

    // Half of the 800 ns link clock period
    task automatic half();
        repeat (4) @(negedge clk_i);
    endtask

    task automatic start(input logic mode3);
        mode3_q = mode3;
        sck_o = mode3;
        half();
        cs_n_o = 1'b0;
        half();
    endtask

    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sck_o = 1'b0;
            si_o = tx[i];
            half();
            rx[i] = so_oe_i ? so_i : 1'bx;
            sck_o = 1'b1;
            half();
        end
    endtask

    task automatic stop();
        if (!mode3_q)
            sck_o = 1'b0;
        si_o = ~si_o;
        half();
        cs_n_o = 1'b1;
        half();
    endtask
endmodule // smcp_host_model

`default_nettype wire

// File: testbench/smcp_top_tb.sv
// Self-checking bench for the serial memory command port.
`timescale 1ns/1ps
`default_nettype none

// ********
// Bench
// ********
module smcp_top_tb;
    import smcp_pkg::*;
    logic        clk;
    logic        rst;
    wire logic   sck;
    wire logic   cs_n;
    wire logic   si;
    wire logic   so;
    wire logic   so_oe;
    wire logic   mode3;
    wire logic [7:0] status;
    int          err_count = 0;
    int          checks_done = 0;
    int          cycles = 0;
    logic [31:0] seed = 32'h42;
    logic        latch_m = 1'b0;
    logic [1:0]  bp_m = 2'h0;
    logic [7:0]  model_m [int];
    logic [7:0]  tx_q [$];
    logic [7:0]  got [$];
    logic [15:0] bases [4] = '{16'h0, 16'h5ffe, 16'h3ffe, 16'h1000};

    smcp_top dut_u (.CLK_I(clk), .RST_I(rst), .SCK_I(sck), .CS_N_I(cs_n), .SI_I(si),
                    .SO_O(so), .SO_OE_O(so_oe), .MODE3_O(mode3), .STATUS_O(status));
    smcp_host_model host_u (.clk_i(clk), .so_i(so), .so_oe_i(so_oe), .sck_o(sck),
                            .cs_n_o(cs_n), .si_o(si));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic prot(input int a);
        case (bp_m)
            2'h1: return a >= 'h6000;
            2'h2: return a >= 'h4000;
            2'h3: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    function automatic logic [7:0] exp_st();
        return {4'h4, bp_m, latch_m, 1'b0};
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic done(input string name);
        $display("test %s ended, mismatches %0d", name, err_count);
    endtask

    // One frame in a random mode; read bytes clock out random input
    task automatic run(input int n_rd);
        logic [7:0]  r;
        logic [31:0] v;
        logic        m;
        v = rnd();
        m = v[0];
        host_u.start(m);
        foreach (tx_q[i])
            host_u.xfer(tx_q[i], r);
        got = {};
        repeat (n_rd) begin
            v = rnd();
            host_u.xfer(v[7:0], r);
            got.push_back(r);
        end
        host_u.stop();
        check({7'h0, mode3}, {7'h0, m});
    endtask

    task automatic op1(input logic [7:0] op, input int n_rd);
        tx_q = {};
        tx_q.push_back(op);
        run(n_rd);
    endtask

    task automatic st_check();
        op1(STATUS_READ_CMD, 1);
        check(got[0], exp_st());
        check(status, exp_st());
    endtask

    task automatic latch_set_cmd();
        op1(LATCH_SET_CMD, 0);
        latch_m = 1'b1;
        check(status, exp_st());
    endtask

    task automatic stat_wr(input logic [1:0] b, input logic en);
        if (en)
            latch_set_cmd();
        tx_q = {};
        tx_q.push_back(STATUS_WRITE_CMD);
        tx_q.push_back({4'hb, b, 2'h3});
        run(0);
        if (latch_m)
            bp_m = b;
        latch_m = 1'b0;
        st_check();
    endtask

    task automatic access(input logic wr, input logic comp, input logic [15:0] adr,
                          input int n, input logic en);
        int          a;
        int          keys [$];
        logic [31:0] v;
        logic        halt;
        if (wr && en)
            latch_set_cmd();
        tx_q = {};
        tx_q.push_back(comp ? (wr ? COMPANION_WRITE_CMD : COMPANION_READ_CMD)
                            : (wr ? MEM_WRITE_CMD : MEM_READ_CMD));
        if (!comp)
            tx_q.push_back(adr[15:8]);
        tx_q.push_back(adr[7:0]);
        a = comp ? int'(adr[7:0]) : int'(adr[14:0]);
        halt = !latch_m;
        keys = {};
        for (int i = 0; i < n; i++) begin
            keys.push_back(comp ? 'h10000 + a : a);
            if (wr) begin
                v = rnd();
                tx_q.push_back(v[7:0]);
                halt = halt | (!comp && prot(a));
                if (!halt)
                    model_m[keys[i]] = v[7:0];
            end
            a = comp ? (a == 29 ? 0 : a + 1) : (a + 1) % 32768;
        end
        run(wr ? 0 : n);
        for (int i = 0; i < n; i++)
            if (!wr && model_m.exists(keys[i]))
                check(got[i], model_m[keys[i]]);
        if (wr)
            latch_m = 1'b0;
        if (wr)
            check(status, exp_st());
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            err_count++;
            finish_test();
        end
    end

    initial begin
        logic [31:0] v;
        logic [15:0] adr;
        rst = 1'b1;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        check(status, 8'h40);
        done("reset");
        st_check();
        latch_set_cmd();
        op1(MEM_READ_CMD, 2);
        st_check();
        op1(LATCH_CLEAR_CMD, 0);
        latch_m = 1'b0;
        st_check();
        stat_wr(2'h3, 1'b0);
        stat_wr(2'h2, 1'b1);
        stat_wr(2'h0, 1'b1);
        done("latch and status");
        access(1'b1, 1'b0, 16'hfffd, 6, 1'b1);
        access(1'b0, 1'b0, 16'h7ffd, 6, 1'b0);
        access(1'b1, 1'b0, 16'h7ffe, 3, 1'b0);
        access(1'b0, 1'b0, 16'h7ffd, 6, 1'b0);
        done("memory burst");
        for (int k = 1; k < 4; k++) begin
            stat_wr(2'h0, 1'b1);
            access(1'b1, 1'b0, bases[k], 4, 1'b1);
            stat_wr(k[1:0], 1'b1);
            access(1'b1, 1'b0, bases[k], 4, 1'b1);
            access(1'b0, 1'b0, bases[k], 4, 1'b0);
        end
        stat_wr(2'h0, 1'b1);
        done("protection");
        access(1'b1, 1'b1, 16'h001c, 3, 1'b1);
        access(1'b0, 1'b1, 16'h001c, 3, 1'b0);
        access(1'b1, 1'b1, 16'h001c, 2, 1'b0);
        access(1'b0, 1'b1, 16'h001d, 2, 1'b0);
        done("companion");
        repeat (8) begin
            v = rnd();
            adr = v[1] ? {12'h0, v[11:8]} : v[31:16];
            access(1'b1, v[1], adr, 1 + int'(v[4:2]), v[5]);
            access(1'b0, v[1], adr, 1 + int'(v[4:2]), 1'b0);
        end
        done("random");
        finish_test();
    end
endmodule // smcp_top_tb

`default_nettype wire
